// *** fllc_core.sv ***
// Frequency locked loop control: registers, digital oscillator, loop filter, output divider
//
// Behaviour
// R1: Reference input divided by 1, 2, 4 or 8 per ref_prediv bits 12:11.
// R2: Software keeps divided reference at or below 13.5MHz.
// R3: Oscillator divided by 2 to 256 per vco_out_divider bits 10:8, default 001.
// R4: Control block runs at oscillator rate over one plus loop_control_rate.
// R5: Ratio 1, 2, 4, 8 for codes 0 to 3, 16 when top bit set.
// R6: Software picks vco_ratio_select from the divided reference frequency band.
// R7: fractional_mode_en selects integer or fractional mode, default fractional.
// R8: mult_fraction is unsigned fraction, top bit weighs one half, reset 3137h.
// R9: Software may compute mult_fraction as fraction times 2^16.
// R10: mult_integer in bits 14:5 of third register, weight one, default 008h.
// R11: Loop error scaled by two to the loop_error_gain, codes up to 1000.
// R12: Software keeps oscillator within 90 to 100 MHz.
// R13: Software derives multiplier from output, divider, ratio and reference.
// R14: Software avoids integer multipliers by changing ratio in fractional mode.
// R15: Software uses output divide by two for 45 to 50 MHz output.
// R16: Loop runs only while loop_enable is set.
// R17: Software clears loop_enable before changing settings, sets it last.
// R18: mult_fraction ignored while fractional_mode_en is clear.
// R19: Output clock held low while loop_enable is clear.
`timescale 1ns/1ps
module fllc_core
  import fllc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Control register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0] o_reg_rdata,
  // Reference pin
  input wire logic i_mclk_ref,
  // Loop output toward system clock selection
  output logic o_fll_clk,
  output logic o_loop_active
);

  // ****************************************
  // Registers
  // ****************************************
  fllc_ctrl_t ctrl;
  fllc_mult_t mult;

  wire wr_primary = i_reg_wr && (i_reg_addr == REG_PRIMARY_ADDR);
  wire wr_fraction = i_reg_wr && (i_reg_addr == REG_FRACTION_ADDR);
  wire wr_intgain = i_reg_wr && (i_reg_addr == REG_INTGAIN_ADDR);
  wire [DATA_W-1:0] rd_primary = {3'h0, ctrl};
  wire [DATA_W-1:0] rd_intgain = {1'b0, mult.mult_integer, 1'b0, mult.loop_error_gain};
  logic [DATA_W-1:0] rd_mux;

  assign rd_mux = (i_reg_addr == REG_PRIMARY_ADDR) ? rd_primary :
                  (i_reg_addr == REG_FRACTION_ADDR) ? mult.mult_fraction :
                  (i_reg_addr == REG_INTGAIN_ADDR) ? rd_intgain : 16'h0000;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= fllc_ctrl_t'(PRIMARY_RST); // R3 R4 R7
      mult.mult_fraction <= FRACTION_RST; // R8
      mult.mult_integer <= N_RST; // R10
      mult.loop_error_gain <= GAIN_RST; // R11
      o_reg_rdata <= 16'h0000;
    end else begin
      if (wr_primary) begin
        ctrl <= fllc_ctrl_t'(i_reg_wdata[PREDIV_LSB+1:ENA_BIT]);
      end
      if (wr_fraction) begin
        mult.mult_fraction <= i_reg_wdata; // R8
      end
      if (wr_intgain) begin
        mult.mult_integer <= i_reg_wdata[N_LSB+9:N_LSB]; // R10
        mult.loop_error_gain <= i_reg_wdata[GAIN_LSB+3:GAIN_LSB];
      end
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ****************************************
  // Divided reference
  // ****************************************
  logic ref_tick;

  fllc_ref_tick u_ref_tick (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_mclk_ref(i_mclk_ref),
    .i_enable(ctrl.loop_enable),
    .i_ref_prediv(ctrl.ref_prediv),
    .o_ref_tick(ref_tick)
  );

  // ****************************************
  // Target count per reference period
  // ****************************************
  function automatic logic [2:0] ratio_shift(input logic [2:0] code);
    ratio_shift = code[2] ? 3'd4 : {1'b0, code[1:0]};
  endfunction

  wire enable = ctrl.loop_enable;
  wire [2:0] shift = ratio_shift(ctrl.vco_ratio_select); // R5
  wire [15:0] eff_k = ctrl.fractional_mode_en ? mult.mult_fraction : 16'h0000; // R7 R18
  wire [25:0] nk = {mult.mult_integer, eff_k};
  wire [29:0] target = 30'({4'h0, nk} << shift);
  wire [3:0] gain = (mult.loop_error_gain > GAIN_MAX) ? GAIN_MAX : mult.loop_error_gain;

  // ****************************************
  // Digital oscillator and measurement
  // ****************************************
  logic [31:0] phase;
  logic [31:0] inc;
  logic dco_tick;
  logic [15:0] meas;
  logic signed [33:0] err_pend;
  logic err_valid;
  logic [2:0] rate_cnt;

  wire [32:0] phase_sum = {1'b0, phase} + {1'b0, inc};
  wire signed [33:0] err_now = $signed({4'h0, target}) - $signed({2'b00, meas, 16'h0000});
  wire signed [41:0] err_gain = 42'(err_pend) <<< gain; // R11
  wire signed [41:0] step = err_gain >>> ERR_SHIFT;
  wire ctrl_en = dco_tick && (rate_cnt == ctrl.loop_control_rate); // R4
  wire upd = ctrl_en && err_valid;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase <= 32'h0000_0000;
      dco_tick <= 1'b0;
    end else if (!enable) begin
      phase <= 32'h0000_0000; // R16
      dco_tick <= 1'b0;
    end else begin
      phase <= phase_sum[31:0];
      dco_tick <= phase_sum[32];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      meas <= 16'h0000;
      err_pend <= 34'sh0;
      err_valid <= 1'b0;
    end else if (!enable) begin
      meas <= 16'h0000; // R16
      err_pend <= 34'sh0;
      err_valid <= 1'b0;
    end else begin
      if (ref_tick) begin
        meas <= {15'h0000, dco_tick};
        err_pend <= err_now;
        err_valid <= 1'b1;
      end else begin
        if (dco_tick && meas != 16'hFFFF) begin
          meas <= meas + 16'h0001;
        end
        if (upd) begin
          err_valid <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Loop control block, clocked by divided oscillator
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_cnt <= 3'h0;
      inc <= INC_INIT;
    end else if (!enable) begin
      rate_cnt <= 3'h0;
      inc <= INC_INIT; // R16
    end else begin
      if (ctrl_en) begin
        rate_cnt <= 3'h0;
      end else if (dco_tick) begin
        rate_cnt <= rate_cnt + 3'h1; // R4
      end
      if (upd) begin
        inc <= inc + step[31:0]; // R11
      end
    end
  end

  // ****************************************
  // Output divider by 2 to 256
  // ****************************************
  logic [6:0] out_cnt;
  wire [6:0] out_last = 7'((8'd1 << ctrl.vco_out_divider) - 8'd1);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_cnt <= 7'h00;
      o_fll_clk <= 1'b0;
      o_loop_active <= 1'b0;
    end else begin
      o_loop_active <= enable; // R16
      if (!enable) begin
        out_cnt <= 7'h00;
        o_fll_clk <= 1'b0; // R19
      end else if (dco_tick) begin
        if (out_cnt >= out_last) begin
          out_cnt <= 7'h00;
          o_fll_clk <= !o_fll_clk; // R3
        end else begin
          out_cnt <= out_cnt + 7'h01;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_out_off;
    @(posedge i_mclk) disable iff (!i_resetn)
    !enable |=> !o_fll_clk && !o_loop_active;
  endproperty
  a_out_off: assert property (p_out_off) else $error("output not held off"); // R19

  property p_out_on_tick;
    @(posedge i_mclk) disable iff (!i_resetn)
    (o_fll_clk != $past(o_fll_clk)) |-> $past(dco_tick) || !$past(enable);
  endproperty
  a_out_on_tick: assert property (p_out_on_tick) else $error("output moved without tick"); // R3

  property p_ratio16;
    @(posedge i_mclk) disable iff (!i_resetn)
    ctrl.vco_ratio_select[2] |-> target == 30'({4'h0, nk} << 4);
  endproperty
  a_ratio16: assert property (p_ratio16) else $error("ratio not 16"); // R5

  property p_int_mode;
    @(posedge i_mclk) disable iff (!i_resetn)
    !ctrl.fractional_mode_en |-> target == 30'({4'h0, mult.mult_integer, 16'h0000} << shift);
  endproperty
  a_int_mode: assert property (p_int_mode) else $error("fraction not ignored"); // R18

  property p_frac_write;
    @(posedge i_mclk) disable iff (!i_resetn)
    wr_fraction |=> mult.mult_fraction == $past(i_reg_wdata);
  endproperty
  a_frac_write: assert property (p_frac_write) else $error("fraction write lost"); // R8

  property p_intgain_read;
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_reg_rd && i_reg_addr == REG_INTGAIN_ADDR && !i_reg_wr) |=>
      o_reg_rdata[14:5] == mult.mult_integer && o_reg_rdata[15] == 1'b0;
  endproperty
  a_intgain_read: assert property (p_intgain_read) else $error("integer readback wrong"); // R10

  property p_inc_only_ctrl;
    @(posedge i_mclk) disable iff (!i_resetn)
    $past(enable) && enable && (inc != $past(inc)) |-> $past(upd);
  endproperty
  a_inc_only_ctrl: assert property (p_inc_only_ctrl) else $error("loop update off rate"); // R4

  property p_gain_step;
    @(posedge i_mclk) disable iff (!i_resetn)
    upd && enable |=> inc == $past(inc) + $past(step[31:0]);
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain step wrong"); // R11

  property p_disable_clear;
    @(posedge i_mclk) disable iff (!i_resetn)
    !enable |=> inc == INC_INIT && phase == 32'h0000_0000 && !dco_tick;
  endproperty
  a_disable_clear: assert property (p_disable_clear) else $error("loop ran while off"); // R16

endmodule

// *** fllc_pkg.sv ***
// Package: register map, field layout, reset values and carriers of the loop control block
package fllc_pkg;

  // ****************************************
  // Register port
  // ****************************************
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  localparam logic [6:0] REG_PRIMARY_ADDR = 7'h08;
  localparam logic [6:0] REG_FRACTION_ADDR = 7'h09;
  localparam logic [6:0] REG_INTGAIN_ADDR = 7'h0A;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned PREDIV_LSB = 11;
  localparam int unsigned OUTDIV_LSB = 8;
  localparam int unsigned RATE_LSB = 5;
  localparam int unsigned RATIO_LSB = 2;
  localparam int unsigned FRAC_BIT = 1;
  localparam int unsigned ENA_BIT = 0;
  localparam int unsigned N_LSB = 5;
  localparam int unsigned GAIN_LSB = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [12:0] PRIMARY_RST = 13'h0102;
  localparam logic [15:0] FRACTION_RST = 16'h3137;
  localparam logic [9:0] N_RST = 10'h008;
  localparam logic [3:0] GAIN_RST = 4'h4;

  // ****************************************
  // Loop arithmetic
  // ****************************************
  localparam logic [3:0] GAIN_MAX = 4'h8;
  localparam int unsigned ERR_SHIFT = 16;
  localparam logic [31:0] INC_INIT = 32'h1000_0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] ref_prediv;
    logic [2:0] vco_out_divider;
    logic [2:0] loop_control_rate;
    logic [2:0] vco_ratio_select;
    logic fractional_mode_en;
    logic loop_enable;
  } fllc_ctrl_t;

  typedef struct packed {
    logic [9:0] mult_integer;
    logic [15:0] mult_fraction;
    logic [3:0] loop_error_gain;
  } fllc_mult_t;

endpackage

// *** fllc_ref_tick.sv ***
// Reference pin synchroniser and reference pre-divider
`timescale 1ns/1ps
module fllc_ref_tick
  import fllc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Reference pin and control
  input wire logic i_mclk_ref,
  input wire logic i_enable,
  input wire logic [1:0] i_ref_prediv,
  // Divided reference
  output logic o_ref_tick
);

  // ****************************************
  // Synchroniser and edge detect
  // ****************************************
  logic sync1;
  logic sync2;
  logic sync3;
  logic level;
  logic [2:0] div_cnt;
  wire agree = (sync2 == sync3);
  wire rise = agree && sync2 && !level;
  wire [2:0] div_last = 3'((4'd1 << i_ref_prediv) - 4'd1);
  wire next_tick = i_enable && rise && (div_cnt == div_last);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      level <= 1'b0;
    end else begin
      sync1 <= i_mclk_ref;
      sync2 <= sync1;
      sync3 <= sync2;
      if (agree) begin
        level <= sync2;
      end
    end
  end

  // ****************************************
  // Pre-divider by 1, 2, 4 or 8
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt <= 3'h0;
      o_ref_tick <= 1'b0;
    end else begin
      o_ref_tick <= next_tick; // R1
      if (!i_enable || next_tick) begin
        div_cnt <= 3'h0;
      end else if (rise) begin
        div_cnt <= div_cnt + 3'h1; // R1
      end
    end
  end

  property p_prediv_tick;
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_enable && rise && div_cnt == div_last) |=> o_ref_tick ##1 !o_ref_tick;
  endproperty
  a_prediv_tick: assert property (p_prediv_tick) else $error("prediv tick wrong"); // R1

endmodule

// *** tb_top.sv ***
// Testbench for the loop control block: register port, enable and output clock
`timescale 1ns/1ps
module tb_top;
  import fllc_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic i_mclk;
  logic i_resetn;
  logic i_reg_wr;
  logic i_reg_rd;
  logic i_mclk_ref;
  logic [ADDR_W-1:0] i_reg_addr;
  logic [DATA_W-1:0] i_reg_wdata;
  logic [DATA_W-1:0] o_reg_rdata;
  logic o_fll_clk;
  logic o_loop_active;
  logic rd_seen = 1'b0;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] val;
  int n_errors = 0;
  int total_checks = 0;
  int n;

  fllc_core dut (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .i_mclk_ref(i_mclk_ref),
    .o_fll_clk(o_fll_clk),
    .o_loop_active(o_loop_active)
  );

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task give_verdict;
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("wrong value read notes expected 0 seen %0d", exp_q.size());
    end
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_mclk);
    #1;
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(posedge i_mclk);
    #1;
    i_reg_wr = 1'b0;
  endtask

  // Read strobe; the expected word is noted for the monitor
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    exp_q.push_back(exp);
    @(posedge i_mclk);
    #1;
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(posedge i_mclk);
    #1;
    i_reg_rd = 1'b0;
  endtask

  // Cycles until the output clock changes level, sampled on falling edges
  task automatic wait_toggle(output int cnt);
    logic last;
    last = o_fll_clk;
    cnt = 0;
    while (o_fll_clk === last && cnt < 4000) begin
      @(negedge i_mclk);
      cnt++;
    end
    if (cnt >= 4000) begin
      n_errors++;
      $display("wrong value output toggle expected edge seen none");
      give_verdict();
    end
  endtask

  // ****************************************
  // Read data monitor
  // ****************************************
  always @(posedge i_mclk) rd_seen <= i_reg_rd;

  always @(negedge i_mclk) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("wrong value read note expected pending seen none");
      end else begin
        check("read data", o_reg_rdata, exp_q.pop_front());
      end
    end
  end

  initial begin
    #2000000;
    n_errors++;
    $display("wrong value run expected finish seen timeout");
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    i_resetn = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = '0;
    i_reg_wdata = '0;
    i_mclk_ref = 1'b0;
    void'($urandom(97));
    repeat (4) @(posedge i_mclk);
    #1;
    i_resetn = 1'b1;
    rd(REG_PRIMARY_ADDR, 16'h0102);
    rd(REG_FRACTION_ADDR, 16'h3137);
    rd(REG_INTGAIN_ADDR, 16'h0104);
    for (int i = 0; i < 12; i++) begin
      val = 16'($urandom());
      case (i % 3)
        0: begin
          wr(REG_PRIMARY_ADDR, val & 16'hFFFE);
          rd(REG_PRIMARY_ADDR, val & 16'h1FFE);
        end
        1: begin
          wr(REG_FRACTION_ADDR, val);
          rd(REG_FRACTION_ADDR, val);
        end
        default: begin
          wr(REG_INTGAIN_ADDR, val);
          rd(REG_INTGAIN_ADDR, val & 16'h7FEF);
        end
      endcase
    end
    for (int g = 0; g < 9; g++) begin
      wr(REG_INTGAIN_ADDR, 16'h0100 | 16'(g));
      rd(REG_INTGAIN_ADDR, 16'h0100 | 16'(g));
    end
    wr(7'h0C, 16'hFFFF);
    rd(7'h0C, 16'h0000);
    rd(7'h0B, 16'h0000);
    // Free-running oscillator with no reference edges: 16 cycles a tick, all divider codes
    for (int c = 0; c < 8; c++) begin
      wr(REG_PRIMARY_ADDR, 16'(c << OUTDIV_LSB) | 16'h0002);
      wr(REG_PRIMARY_ADDR, 16'(c << OUTDIV_LSB) | 16'h0003);
      repeat (2) @(negedge i_mclk);
      check("loop active", 16'(o_loop_active), 16'h0001);
      wait_toggle(n);
      wait_toggle(n);
      check("output half period", 16'(n), 16'(16 << c));
      wr(REG_PRIMARY_ADDR, 16'h0002);
      repeat (2) @(negedge i_mclk);
      check("clock held", 16'(o_fll_clk), 16'h0000);
      check("loop idle", 16'(o_loop_active), 16'h0000);
    end
    // Integer mode with divided reference edges, settings first, enable last, then stop
    wr(REG_FRACTION_ADDR, 16'h0000);
    wr(REG_INTGAIN_ADDR, 16'h0100);
    wr(REG_PRIMARY_ADDR, 16'h1804);
    wr(REG_PRIMARY_ADDR, 16'h1805);
    repeat (40) begin
      repeat (5) @(posedge i_mclk);
      #1;
      i_mclk_ref = ~i_mclk_ref;
    end
    check("loop running", 16'(o_loop_active), 16'h0001);
    wr(REG_PRIMARY_ADDR, 16'h0000);
    repeat (2) @(negedge i_mclk);
    check("clock stopped", 16'(o_fll_clk), 16'h0000);
    // Second reset in mid-run restores the defaults
    wr(REG_PRIMARY_ADDR, 16'h0101);
    @(posedge i_mclk);
    #1;
    i_resetn = 1'b0;
    @(negedge i_mclk);
    check("clock in reset", 16'(o_fll_clk), 16'h0000);
    check("active in reset", 16'(o_loop_active), 16'h0000);
    repeat (4) @(posedge i_mclk);
    #1;
    i_resetn = 1'b1;
    rd(REG_FRACTION_ADDR, 16'h3137);
    rd(REG_PRIMARY_ADDR, 16'h0102);
    rd(REG_INTGAIN_ADDR, 16'h0104);
    repeat (3) @(posedge i_mclk);
    give_verdict();
  end
endmodule
